//--- src/ext_strobe_gate.sv
// Flash address forming and read/write strobe gating for external moves
`timescale 1ns/1ns
module ext_strobe_gate #(
	parameter int EXT_W     = 16,
	parameter int BANK_W    = 3,
	parameter int AUX_BYTES = 512
) (
	input  wire logic [EXT_W-1:0]        i_ext_addr,
	input  wire logic [BANK_W-1:0]       i_bank_sel,
	input  wire logic                    i_external_move_instr,
	input  wire logic                    i_aux_ram_disable,
	input  wire logic                    i_rd_n,
	input  wire logic                    i_wr_n,
	output logic      [EXT_W+BANK_W-1:0] o_flash_addr,
	output logic                         o_rd_n,
	output logic                         o_wr_n,
	output logic                         o_aux_ram_sel
);
	if (AUX_BYTES < 1 || AUX_BYTES > (1 << EXT_W)) begin : bad_aux_size
		$error("AUX_BYTES does not fit the external address space");
	end

	localparam logic [EXT_W-1:0] AUX_LIMIT = EXT_W'(AUX_BYTES);

	always_comb begin
		o_flash_addr  = {i_bank_sel, i_ext_addr};
		// Lower block goes to the on-chip RAM unless disabled; upper is always external
		o_aux_ram_sel = i_external_move_instr && !i_aux_ram_disable
			&& (i_ext_addr < AUX_LIMIT);
		o_rd_n        = i_rd_n | o_aux_ram_sel;
		o_wr_n        = i_wr_n | o_aux_ram_sel;
	end
endmodule // ext_strobe_gate

//--- src/flash_bank_port_and_power_control.sv
// Bank port and power control registers with flash pin multiplexing
`timescale 1ns/1ns
module flash_bank_port_and_power_control #(
	parameter int PORT_W = 6,
	parameter int BANK_W = 3
) (
	input  wire logic                                i_clock,
	input  wire logic                                i_sys_rst,
	input  wire logic [7:0]                          i_sfr_addr,
	input  wire logic                                i_sfr_wr,
	input  wire logic [7:0]                          i_sfr_wdata,
	output logic      [7:0]                          o_sfr_rdata,
	output logic                                     o_sfr_hit,
	input  wire logic [flash_port_pkg::EXT_ADDR_W-1:0] i_ext_addr,
	input  wire logic                                i_external_move_instr,
	input  wire logic                                i_rd_n,
	input  wire logic                                i_wr_n,
	input  wire logic                                i_wdt_loaded,
	input  wire logic                                i_wake_event,
	input  wire logic                                i_shift_busy,
	input  wire logic                                i_gp_clock_output,
	input  wire logic                                i_alt_bit0_output,
	input  wire logic                                i_serial_flash_clk,
	input  wire logic                                i_serial_flash_dout,
	input  wire logic [PORT_W-1:0]                   i_port_in,
	output logic      [PORT_W-1:0]                   o_port_out,
	output logic      [PORT_W-1:0]                   o_port_oe_n,
	output logic                                     o_serial_flash_din,
	output logic [flash_port_pkg::FLASH_ADDR_W-1:0]  o_flash_addr,
	output logic                                     o_rd_n,
	output logic                                     o_wr_n,
	output logic                                     o_aux_ram_sel,
	output logic                                     o_serial_mode,
	output logic                                     o_watchdog_load_enable,
	output logic                                     o_powerdown_select,
	output logic                                     o_low_activity_select
);
	import flash_port_pkg::*;

	if (PORT_W != PORT_BITS || BANK_W != BANK_SEL_W) begin : bad_params
		$error("port and bank widths are fixed by the register layout");
	end

	typedef struct packed {
		logic [PORT_W-1:0] bank_port_reg;
		logic [7:0]        power_control_reg;
		logic [7:0]        memory_serial_command_reg;
	} regs_t;

	regs_t state;
	regs_t next_state;

	function automatic logic [7:0] read_mux(input logic [7:0] addr, input regs_t r);
		logic [7:0] val;
		val = 8'h00;
		case (addr)
			BANK_PORT_ADDR:      val = {2'b00, r.bank_port_reg};
			POWER_CTRL_ADDR:     val = r.power_control_reg;
			MEM_SERIAL_CMD_ADDR: val = r.memory_serial_command_reg;
			default:             val = 8'h00;
		endcase
		return val;
	endfunction

	function automatic logic is_mapped(input logic [7:0] addr);
		return (addr == BANK_PORT_ADDR) || (addr == POWER_CTRL_ADDR)
			|| (addr == MEM_SERIAL_CMD_ADDR);
	endfunction

	logic wr_bank;
	logic wr_power;
	logic wr_cmd;

	always_comb begin
		wr_bank  = i_sfr_wr && (i_sfr_addr == BANK_PORT_ADDR);
		wr_power = i_sfr_wr && (i_sfr_addr == POWER_CTRL_ADDR);
		wr_cmd   = i_sfr_wr && (i_sfr_addr == MEM_SERIAL_CMD_ADDR);
		next_state = state;
		// Hardware clears act first so a same-cycle software write wins
		if (i_wdt_loaded) begin
			next_state.power_control_reg[WDT_LOAD_BIT] = 1'b0;
		end
		if (i_wake_event) begin
			next_state.power_control_reg[PWRDOWN_BIT] = 1'b0;
			next_state.power_control_reg[LOW_ACT_BIT] = 1'b0;
		end
		if (wr_bank) begin
			next_state.bank_port_reg = i_sfr_wdata[PORT_W-1:0];
		end
		if (wr_power) begin
			next_state.power_control_reg = i_sfr_wdata;
		end
		if (wr_cmd) begin
			next_state.memory_serial_command_reg = i_sfr_wdata;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state.bank_port_reg             <= BANK_PORT_RESET[PORT_W-1:0];
			state.power_control_reg         <= POWER_CTRL_RESET;
			state.memory_serial_command_reg <= MEM_SERIAL_CMD_RESET;
		end else begin
			state <= next_state;
		end
	end

	always_comb begin
		o_sfr_rdata            = read_mux(i_sfr_addr, state);
		o_sfr_hit              = is_mapped(i_sfr_addr);
		o_serial_mode          = state.memory_serial_command_reg[MCB_ON_BIT];
		o_watchdog_load_enable = state.power_control_reg[WDT_LOAD_BIT];
		o_powerdown_select     = state.power_control_reg[PWRDOWN_BIT];
		o_low_activity_select  = state.power_control_reg[LOW_ACT_BIT];
		o_serial_flash_din     = i_port_in[SDIN_BIT];
	end

	ext_strobe_gate #(
		.EXT_W     (EXT_ADDR_W),
		.BANK_W    (BANK_W),
		.AUX_BYTES (AUX_RAM_BYTES)
	) u_strobe (
		.i_ext_addr            (i_ext_addr),
		.i_bank_sel            (state.bank_port_reg[BANK_W-1:0]),
		.i_external_move_instr (i_external_move_instr),
		.i_aux_ram_disable     (state.power_control_reg[AUX_DIS_BIT]),
		.i_rd_n                (i_rd_n),
		.i_wr_n                (i_wr_n),
		.o_flash_addr          (o_flash_addr),
		.o_rd_n                (o_rd_n),
		.o_wr_n                (o_wr_n),
		.o_aux_ram_sel         (o_aux_ram_sel)
	);

	// Bit 3 is a plain latch pin that gates the flash chip enable
	port_pin_driver #(
		.WIDTH (PORT_W)
	) u_pins (
		.i_latch             (state.bank_port_reg),
		.i_serial_mode       (o_serial_mode),
		.i_shift_busy        (i_shift_busy),
		.i_gp_clock_output   (i_gp_clock_output),
		.i_alt_bit0_output   (i_alt_bit0_output),
		.i_serial_flash_clk  (i_serial_flash_clk),
		.i_serial_flash_dout (i_serial_flash_dout),
		.o_pin_out           (o_port_out),
		.o_pin_oe_n          (o_port_oe_n)
	);

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);

	aux_strobe_high_a: assert property (
		o_aux_ram_sel |-> (o_rd_n && o_wr_n))
		else $error("strobe active during aux RAM access");

	bank_address_a: assert property (
		o_flash_addr == {state.bank_port_reg[2:0], i_ext_addr})
		else $error("flash address does not follow bank bits");

	bank_write_a: assert property (
		wr_bank |=> o_flash_addr[FLASH_ADDR_W-1:EXT_ADDR_W] == $past(i_sfr_wdata[2:0]))
		else $error("bank write did not reach the flash address");

	high_bits_absent_a: assert property (
		(i_sfr_addr == BANK_PORT_ADDR) |-> (o_sfr_rdata[7:6] == 2'b00))
		else $error("bank port upper bits read nonzero");

	wle_clear_a: assert property (
		(i_wdt_loaded && !(wr_power && i_sfr_wdata[WDT_LOAD_BIT]))
		|=> !o_watchdog_load_enable)
		else $error("watchdog load enable not cleared after load");

	powerdown_enter_a: assert property (
		(wr_power && i_sfr_wdata[PWRDOWN_BIT]) |=> o_powerdown_select)
		else $error("power-down not entered");

	idle_enter_a: assert property (
		(wr_power && i_sfr_wdata[LOW_ACT_BIT]) |=> o_low_activity_select)
		else $error("idle not entered");

	gp_flags_a: assert property (
		(wr_power && !i_wdt_loaded) |=> (state.power_control_reg[3:2] == $past(i_sfr_wdata[3:2])))
		else $error("general flags not stored");

	serial_din_a: assert property (
		o_serial_mode |-> o_port_oe_n[SDIN_BIT])
		else $error("serial input pin still driven");

	serial_idle_low_a: assert property (
		(o_serial_mode && !i_shift_busy) |-> (!o_port_out[SCLK_BIT] && !o_port_out[SDOUT_BIT]))
		else $error("serial clock or data not low while idle");

	and_gating_a: assert property (
		!state.bank_port_reg[GPC_BIT] |-> !o_port_out[GPC_BIT])
		else $error("alternative output passed a cleared latch");

	aux_disable_a: assert property (
		state.power_control_reg[AUX_DIS_BIT] |-> !o_aux_ram_sel)
		else $error("aux RAM selected while disabled");

	chip_enable_a: assert property (
		o_port_out[CHIP_EN_BIT] == state.bank_port_reg[CHIP_EN_BIT])
		else $error("chip enable pin does not follow its latch");
endmodule // flash_bank_port_and_power_control

//--- src/flash_port_pkg.sv
// Constants for the flash bank port and power control logic
package flash_port_pkg;
	localparam logic [7:0] BANK_PORT_ADDR       = 8'h98;
	localparam logic [7:0] POWER_CTRL_ADDR      = 8'h87;
	localparam logic [7:0] MEM_SERIAL_CMD_ADDR  = 8'ha9;
	localparam logic [7:0] BANK_PORT_RESET      = 8'h1e;
	localparam logic [7:0] POWER_CTRL_RESET     = 8'h00;
	localparam logic [7:0] MEM_SERIAL_CMD_RESET = 8'h00;
	localparam int PORT_BITS     = 6;
	localparam int BANK_SEL_W    = 3;
	localparam int ALT0_BIT      = 0;
	localparam int SCLK_BIT      = 1;
	localparam int SDOUT_BIT     = 2;
	localparam int CHIP_EN_BIT   = 3;
	localparam int SDIN_BIT      = 4;
	localparam int GPC_BIT       = 5;
	localparam int LOW_ACT_BIT   = 0;
	localparam int PWRDOWN_BIT   = 1;
	localparam int GFLAG0_BIT    = 2;
	localparam int GFLAG1_BIT    = 3;
	localparam int WDT_LOAD_BIT  = 4;
	localparam int AUX_DIS_BIT   = 6;
	localparam int MCB_ON_BIT    = 3;
	localparam int EXT_ADDR_W    = 16;
	localparam int FLASH_ADDR_W  = EXT_ADDR_W + BANK_SEL_W;
	localparam int AUX_RAM_BYTES = 512;
endpackage

//--- src/port_pin_driver.sv
// Port pin drivers with alternative functions ANDed onto the port latch
`timescale 1ns/1ns
module port_pin_driver #(
	parameter int WIDTH = 6
) (
	input  wire logic [WIDTH-1:0] i_latch,
	input  wire logic             i_serial_mode,
	input  wire logic             i_shift_busy,
	input  wire logic             i_gp_clock_output,
	input  wire logic             i_alt_bit0_output,
	input  wire logic             i_serial_flash_clk,
	input  wire logic             i_serial_flash_dout,
	output logic      [WIDTH-1:0] o_pin_out,
	output logic      [WIDTH-1:0] o_pin_oe_n
);
	import flash_port_pkg::*;

	if (WIDTH != PORT_BITS) begin : bad_width
		$error("port width must match the implemented port bits");
	end

	logic serial_live;

	always_comb begin
		serial_live = i_serial_mode && i_shift_busy;
		o_pin_out   = i_latch;
		o_pin_oe_n  = '0;
		o_pin_out[ALT0_BIT] = i_latch[ALT0_BIT] & i_alt_bit0_output;
		o_pin_out[GPC_BIT]  = i_latch[GPC_BIT] & i_gp_clock_output;
		if (i_serial_mode) begin
			// Idle engine holds clock and data low once switched on
			o_pin_out[SCLK_BIT]  = i_latch[SCLK_BIT] & i_serial_flash_clk & serial_live;
			o_pin_out[SDOUT_BIT] = i_latch[SDOUT_BIT] & i_serial_flash_dout & serial_live;
			// Open drain: drive only a low level
			o_pin_oe_n[SCLK_BIT]  = o_pin_out[SCLK_BIT];
			o_pin_oe_n[SDOUT_BIT] = o_pin_out[SDOUT_BIT];
			o_pin_oe_n[SDIN_BIT]  = 1'b1;
		end
	end
endmodule // port_pin_driver

//--- verification/flash_bank_port_and_power_control_bench.sv
// Self-checking bench for the flash bank port and power control block
`timescale 1ns/1ns
module flash_bank_port_and_power_control_bench;
	import flash_port_pkg::*;
	typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rdata; logic hit;} row_t;
	logic        i_clock, i_sys_rst, i_sfr_wr, i_external_move_instr, i_rd_n, i_wr_n;
	logic        i_wdt_loaded, i_wake_event, i_shift_busy, i_gp_clock_output;
	logic        i_alt_bit0_output, i_serial_flash_clk, i_serial_flash_dout;
	logic [7:0]  i_sfr_addr, i_sfr_wdata, o_sfr_rdata;
	logic [15:0] i_ext_addr;
	logic [5:0]  i_port_in, o_port_out, o_port_oe_n;
	logic [18:0] o_flash_addr, last_addr;
	logic        o_sfr_hit, o_serial_flash_din, o_rd_n, o_wr_n, o_aux_ram_sel, o_serial_mode;
	logic        o_watchdog_load_enable, o_powerdown_select, o_low_activity_select, sdo;
	logic        pin_sclk, pin_sdout;
	int          miscompares = 0;
	int          total_checks = 0;
	row_t rows [6] = '{'{8'h98, 8'hff, 8'h3f, 1'b1}, '{8'h87, 8'hac, 8'hac, 1'b1},
		'{8'h87, 8'h00, 8'h00, 1'b1}, '{8'ha9, 8'h08, 8'h08, 1'b1},
		'{8'ha9, 8'h00, 8'h00, 1'b1}, '{8'h55, 8'h5a, 8'h00, 1'b0}};
	// Open-drain serial pins are pulled up when not driven
	assign pin_sclk  = o_port_oe_n[1] ? 1'b1 : o_port_out[1];
	assign pin_sdout = o_port_oe_n[2] ? 1'b1 : o_port_out[2];
	assign i_port_in = {1'b0, sdo, 4'h0};
	flash_bank_port_and_power_control u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
		.i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
		.o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit), .i_ext_addr(i_ext_addr),
		.i_external_move_instr(i_external_move_instr), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n),
		.i_wdt_loaded(i_wdt_loaded), .i_wake_event(i_wake_event),
		.i_shift_busy(i_shift_busy), .i_gp_clock_output(i_gp_clock_output),
		.i_alt_bit0_output(i_alt_bit0_output), .i_serial_flash_clk(i_serial_flash_clk),
		.i_serial_flash_dout(i_serial_flash_dout), .i_port_in(i_port_in),
		.o_port_out(o_port_out), .o_port_oe_n(o_port_oe_n),
		.o_serial_flash_din(o_serial_flash_din), .o_flash_addr(o_flash_addr),
		.o_rd_n(o_rd_n), .o_wr_n(o_wr_n), .o_aux_ram_sel(o_aux_ram_sel),
		.o_serial_mode(o_serial_mode), .o_watchdog_load_enable(o_watchdog_load_enable),
		.o_powerdown_select(o_powerdown_select),
		.o_low_activity_select(o_low_activity_select));
	flash_memory_model u_flash (.i_clock(i_clock), .i_addr(o_flash_addr),
		.i_chip_enable_n(o_port_out[3]), .i_oe_n(o_rd_n), .i_we_n(o_wr_n),
		.i_sclk(pin_sclk), .i_sdi(pin_sdout), .o_sdo(sdo), .o_last_addr(last_addr));
	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end
	task automatic chk_val(input string what, input logic [18:0] exp, input logic [18:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		chk_val(what, {18'h0, exp}, {18'h0, got});
	endtask
	task automatic test_done;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		i_sfr_addr = a;
		i_sfr_wdata = d;
		i_sfr_wr = 1'b1;
		@(posedge i_clock);
		#2 i_sfr_wr = 1'b0;
		// Let one edge pass so a following write never re-raises the strobe at once
		@(posedge i_clock);
		#2;
	endtask
	initial begin
		repeat (100000) @(posedge i_clock);
		miscompares++;
		test_done();
	end
	initial begin
		{i_sfr_wr, i_external_move_instr, i_wdt_loaded, i_wake_event, i_shift_busy} = '0;
		{i_rd_n, i_wr_n, i_gp_clock_output, i_alt_bit0_output} = 4'hf;
		{i_serial_flash_clk, i_serial_flash_dout} = 2'b11;
		i_sfr_addr = 8'h00;
		i_sfr_wdata = 8'h00;
		i_ext_addr = 16'hbeef;
		i_sys_rst = 1'b1;
		repeat (16) @(posedge i_clock);
		#2 i_sys_rst = 1'b0;
		i_sfr_addr = BANK_PORT_ADDR;
		#1 chk_val("bank reset", {11'h0, BANK_PORT_RESET}, {11'h0, o_sfr_rdata});
		chk_val("pins reset", 19'h1e, {13'h0, o_port_out});
		chk_val("oe reset", 19'h0, {13'h0, o_port_oe_n});
		chk_val("addr reset", {3'b110, 16'hbeef}, o_flash_addr);
		i_sfr_addr = POWER_CTRL_ADDR;
		#1 chk_val("power reset", {11'h0, POWER_CTRL_RESET}, {11'h0, o_sfr_rdata});
		for (int k = 0; k < 6; k++) begin
			sfr_write(rows[k].addr, rows[k].wdata);
			#1 chk_val("readback", {11'h0, rows[k].rdata}, {11'h0, o_sfr_rdata});
			chk_bit("hit", rows[k].hit, o_sfr_hit);
		end
		// Every bank with a read strobe reaching the selected flash
		for (int b = 0; b < 8; b++) begin
			sfr_write(BANK_PORT_ADDR, 8'h10 | 8'(b));
			i_rd_n = 1'b0;
			@(posedge i_clock);
			#2 i_rd_n = 1'b1;
			chk_val("flash addr", {3'(b), 16'hbeef}, o_flash_addr);
			chk_val("flash capture", {3'(b), 16'hbeef}, last_addr);
		end
		chk_bit("chip enable", 1'b0, o_port_out[3]);
		// Strobes toward the aux RAM window and outside it
		{i_external_move_instr, i_ext_addr, i_rd_n, i_wr_n} = {1'b1, 16'h0010, 2'b00};
		#1 chk_val("aux strobes", 19'h7, {16'h0, o_aux_ram_sel, o_rd_n, o_wr_n});
		i_ext_addr = 16'h0200;
		#1 chk_val("upper strobes", 19'h0, {16'h0, o_aux_ram_sel, o_rd_n, o_wr_n});
		i_ext_addr = 16'h0010;
		sfr_write(POWER_CTRL_ADDR, 8'h40);
		chk_val("ard strobes", 19'h0, {16'h0, o_aux_ram_sel, o_rd_n, o_wr_n});
		{i_external_move_instr, i_rd_n, i_wr_n} = 3'b011;
		// Watchdog load flag cleared by the load, modes cleared by wake
		sfr_write(POWER_CTRL_ADDR, 8'h13);
		chk_val("modes", 19'h7, {16'h0, o_watchdog_load_enable, o_powerdown_select,
			o_low_activity_select});
		i_wdt_loaded = 1'b1;
		@(posedge i_clock);
		#2 i_wdt_loaded = 1'b0;
		chk_bit("load clear", 1'b0, o_watchdog_load_enable);
		i_wake_event = 1'b1;
		@(posedge i_clock);
		#2 i_wake_event = 1'b0;
		chk_val("wake", 19'h0, {17'h0, o_powerdown_select, o_low_activity_select});
		// Alternative outputs gated by their latch bits
		sfr_write(BANK_PORT_ADDR, 8'h21);
		{i_alt_bit0_output, i_gp_clock_output} = 2'b01;
		#1 chk_val("alt gate a", 19'h20, {13'h0, o_port_out & 6'h21});
		{i_alt_bit0_output, i_gp_clock_output} = 2'b10;
		#1 chk_val("alt gate b", 19'h01, {13'h0, o_port_out & 6'h21});
		sfr_write(BANK_PORT_ADDR, 8'h00);
		chk_val("latch low", 19'h0, {13'h0, o_port_out & 6'h21});
		// Serial flash: idle pins low, then shift a one and seven zeros into the model
		sfr_write(BANK_PORT_ADDR, 8'h16);
		sfr_write(MEM_SERIAL_CMD_ADDR, 8'h08);
		chk_bit("serial mode", 1'b1, o_serial_mode);
		chk_val("serial idle", 19'h0, {17'h0, pin_sclk, pin_sdout});
		chk_bit("din released", 1'b1, o_port_oe_n[4]);
		// Eight rising serial clocks: a one, then seven zeros, so the one ends on top
		i_shift_busy = 1'b1;
		for (int s = 0; s < 16; s++) begin
			i_serial_flash_clk = s[0];
			i_serial_flash_dout = (s < 2);
			@(posedge i_clock);
			#2;
		end
		chk_bit("serial din", 1'b1, o_serial_flash_din);
		// Reset in mid-run brings the registers back to their reset values
		i_sys_rst = 1'b1;
		@(posedge i_clock);
		#2 i_sys_rst = 1'b0;
		i_sfr_addr = BANK_PORT_ADDR;
		#1 chk_val("bank rerun", {11'h0, BANK_PORT_RESET}, {11'h0, o_sfr_rdata});
		chk_bit("serial rerun", 1'b0, o_serial_mode);
		test_done();
	end
endmodule // flash_bank_port_and_power_control_bench

//--- verification/flash_memory_model.sv
// Behavioural external flash: parallel address capture and serial shift register
`timescale 1ns/1ns
module flash_memory_model (
	input  wire logic        i_clock,
	input  wire logic [18:0] i_addr,
	input  wire logic        i_chip_enable_n,
	input  wire logic        i_oe_n,
	input  wire logic        i_we_n,
	input  wire logic        i_sclk,
	input  wire logic        i_sdi,
	output logic             o_sdo,
	output logic      [18:0] o_last_addr
);
	logic [7:0] shift = 8'ha5;
	// Parallel or latched flash takes the address while selected and strobed
	always @(posedge i_clock) begin
		if (!i_chip_enable_n && (!i_oe_n || !i_we_n)) begin
			o_last_addr <= i_addr;
		end
	end
	// Serial flash shifts on the rising serial clock only while selected
	always @(posedge i_sclk) begin
		if (!i_chip_enable_n) begin
			shift <= {shift[6:0], i_sdi};
		end
	end
	// A deselected flash floats its output; show the inverse so a stale sample is caught
	assign o_sdo = i_chip_enable_n ? ~shift[7] : shift[7];
endmodule // flash_memory_model
